// ===== rtc_time_calendar_update.sv
// Time-of-day, calendar and alarm core with its control and status registers.
// Assumes the index/data port strobes are synchronous one-cycle pulses on sys_clk_in.
`timescale 1ns/1ps

// Behaviour
// - A bit7, B bits 3 and 0, shared bits 7-1 read-only
// - All ten bytes binary or BCD per format
// - Hour format 1-12 or 0-23, bit7 PM
// - Once per second advance time, check alarm
// - Seconds carry through minutes up to year
// - Month end and leap years handled automatically
// - Alarm when all three bytes match/wildcard
// - Alarm byte with top bits 11 matches all
// - Fields kept within their documented valid ranges
// - Update only when halt clear, divider running
// - Pending flag rises 244 us before update
// - Update lasts 1948 us, flag held throughout
// - Flag read-only, power-reset proof, halt clears it
// - Control registers accessible even during update
// - Divider code selects off, normal, test, reset; the test codes run as normal
// - First update half second after divider reset
// - Divider bits read/write, power-reset proof
// - Rate select picks periodic tap or none
// - Format bit one binary, zero BCD
// - Hour bit one 24-hour, zero 12-hour
module rtc_time_calendar_update #(
  parameter longint TICK_INC = rtc_pkg::TB_HZ   // Time base added per clock; raise it to speed up simulation.
) (
  input  wire logic       sys_clk_in,              // 200 MHz system clock.
  input  wire logic       rst_in,                  // Full reset, synchronous, active high.
  input  wire logic       main_power_reset_in,     // Main-power reset level, active high.
  input  wire logic       port_data_sel_in,        // Low addresses the index port, high the data port.
  input  wire logic       port_wr_in,              // One-cycle write strobe.
  input  wire logic       port_rd_in,              // One-cycle read strobe.
  input  wire logic [7:0] port_wdata_in,           // Write data.
  output logic      [7:0] port_rdata_out,          // Read data, registered.
  output logic            update_pending_flag_out  // Update pending, registered.
);
  import rtc_pkg::*;

  // Time base and divider chain state.
  logic [31:0]            acc_reg, acc_next;       // Fractional accumulator for the 32.768 KHz enable.
  logic [CHAIN_BITS-1:0]  chain_reg, chain_next;   // Low stages of the divider chain.
  logic [6:0]             upd_reg, upd_next;       // Remaining ticks of the running update.
  logic                   uip_reg, uip_next;       // Update pending flag.
  // Register file state.
  rtc_time_t              tm_reg, tm_next;         // Counting bytes.
  logic [7:0]             alm_sec_reg, alm_sec_next;
  logic [7:0]             alm_min_reg, alm_min_next;
  logic [7:0]             alm_hour_reg, alm_hour_next;
  logic [6:0]             ctrl_a_reg, ctrl_a_next; // Divider control and rate select.
  logic [7:0]             ctrl_b_reg, ctrl_b_next;
  logic                   pf_reg, pf_next;         // Periodic flag.
  logic                   af_reg, af_next;         // Alarm flag.
  logic                   uf_reg, uf_next;         // Update-ended flag.
  logic                   vrt_reg, vrt_next;       // Valid time flag.
  logic                   shared_reg, shared_next; // Writable bit of the shared control register.
  logic [7:0]             index_reg, index_next;   // Index port.
  logic [7:0]             rdata_reg, rdata_next;

  // Decoded controls.
  logic       tick;         // One-cycle 32.768 KHz enable.
  logic       binary;       // Binary encoding selected.
  logic       h24;          // 24-hour mode selected.
  logic       halt;         // Update halt bit.
  logic       div_reset;    // Divider held in reset.
  logic       osc_on;       // Oscillator running.
  logic       upd_ok;       // Updates allowed.
  logic       upd_start;    // Update begins this cycle.
  logic       periodic_hit; // Selected tap edge on this tick.
  logic [3:0] tap;          // Chain stage of the selected rate.
  logic [7:0] reg_c;        // Assembled status C.
  logic [7:0] reg_a;        // Assembled control A.
  logic       wr_data;      // Data-port write.
  logic       rd_data;      // Data-port read.
  wire rtc_time_t tm_adv;   // Advanced counting bytes, one driver per field.
  logic       c_sec, c_min, c_hour, c_mday, c_mon;
  logic [7:0] hour_bin, hour_new, dim;
  logic [7:0] hour_adv;     // Advanced hours byte, same encoding as the register.
  logic       alarm_hit;

  assign binary    = ctrl_b_reg[B_DM_BIT];
  assign h24       = ctrl_b_reg[B_H24_BIT];
  assign halt      = ctrl_b_reg[B_SET_BIT];
  assign div_reset = (ctrl_a_reg[6:5] == DV_RESET_HI);
  assign osc_on    = (ctrl_a_reg[6:4] != DV_OSC_OFF0) && (ctrl_a_reg[6:4] != DV_OSC_OFF1);
  assign upd_ok    = !halt && !div_reset && osc_on;
  assign upd_start = tick && upd_ok && (chain_reg == CHAIN_LAST);
  assign wr_data   = port_wr_in && port_data_sel_in && !main_power_reset_in;
  assign rd_data   = port_rd_in && port_data_sel_in && !main_power_reset_in;

  // Periodic tap: codes 1 and 2 reuse the slow stages, 3 and up step one stage per code.
  always_comb begin
    tap = (ctrl_a_reg[3:0] < 4'h3) ? ctrl_a_reg[3:0] + 4'h6 : ctrl_a_reg[3:0] - 4'h1;
    periodic_hit = tick && osc_on && (ctrl_a_reg[3:0] != 4'h0) &&
                   ((chain_reg & CHAIN_BITS'((16'h0001 << tap) - 16'h0001)) == '0);
  end

  // Counting fields that share the plain wrap rule use the step unit.
  rtc_field_step u_sec (.value_in(tm_reg.sec), .binary_in(binary), .low_in(8'h00), .high_in(MAX_SEC),
                        .carry_in(1'b1), .value_out(tm_adv.sec), .carry_out(c_sec));
  rtc_field_step u_min (.value_in(tm_reg.min), .binary_in(binary), .low_in(8'h00), .high_in(MAX_SEC),
                        .carry_in(c_sec), .value_out(tm_adv.min), .carry_out(c_min));
  rtc_field_step u_wday (.value_in(tm_reg.wday), .binary_in(binary), .low_in(DAY_ONE), .high_in(MAX_WDAY),
                         .carry_in(c_hour), .value_out(tm_adv.wday), .carry_out());
  rtc_field_step u_mday (.value_in(tm_reg.mday), .binary_in(binary), .low_in(DAY_ONE), .high_in(dim),
                         .carry_in(c_hour), .value_out(tm_adv.mday), .carry_out(c_mday));
  rtc_field_step u_mon (.value_in(tm_reg.mon), .binary_in(binary), .low_in(DAY_ONE), .high_in(MAX_MON),
                        .carry_in(c_mday), .value_out(tm_adv.mon), .carry_out(c_mon));
  rtc_field_step u_year (.value_in(tm_reg.year), .binary_in(binary), .low_in(8'h00), .high_in(MAX_YEAR),
                         .carry_in(c_mon), .value_out(tm_adv.year), .carry_out());

  // Hours need their own rule for the 12-hour PM bit, and the month length needs the year.
  always_comb begin
    dim      = month_days(binary ? tm_reg.mon : bcd_to_bin(tm_reg.mon),
                          binary ? tm_reg.year : bcd_to_bin(tm_reg.year));
    hour_bin = binary ? {1'b0, tm_reg.hour[6:0]} : bcd_to_bin({1'b0, tm_reg.hour[6:0]});
    hour_new = hour_bin;
    c_hour   = 1'b0;
    hour_adv = tm_reg.hour;
    if (c_min) begin
      if (h24) begin
        if (hour_bin >= MAX_HOUR) begin
          hour_new = 8'h00;
          c_hour   = 1'b1;
        end else begin
          hour_new = hour_bin + 8'h01;
        end
        hour_adv = binary ? hour_new : bin_to_bcd(hour_new);
      end else begin
        // Twelve rolls to one; eleven rolls to twelve and flips AM/PM, a day ends at PM.
        if (hour_bin >= HOUR_12) begin
          hour_new = DAY_ONE;
        end else begin
          hour_new = hour_bin + 8'h01;
        end
        c_hour = (hour_bin == HOUR_11) && tm_reg.hour[7];
        hour_adv = {tm_reg.hour[7] ^ (hour_bin == HOUR_11),
                    7'(binary ? hour_new : bin_to_bcd(hour_new))};
      end
    end
  end

  assign tm_adv.hour = hour_adv;

  // Alarm check runs on the advanced time; a byte with both top bits set matches anything.
  always_comb begin
    alarm_hit = ((alm_sec_reg[7:6] == WILD_CODE) || (alm_sec_reg == tm_adv.sec)) &&
                ((alm_min_reg[7:6] == WILD_CODE) || (alm_min_reg == tm_adv.min)) &&
                ((alm_hour_reg[7:6] == WILD_CODE) || (alm_hour_reg == tm_adv.hour));
  end

  // Status read-back assembly.
  always_comb begin
    reg_c = {((pf_reg && ctrl_b_reg[B_PIE_BIT]) || (af_reg && ctrl_b_reg[B_AIE_BIT]) ||
              (uf_reg && ctrl_b_reg[B_UIE_BIT])), pf_reg, af_reg, uf_reg, 4'h0};
    reg_a = {uip_reg, ctrl_a_reg};
  end

  // Time base, divider chain and update sequencing.
  always_comb begin
    acc_next   = acc_reg + 32'(TICK_INC);
    tick       = 1'b0;
    if (acc_next >= 32'(SYS_HZ)) begin
      acc_next = acc_next - 32'(SYS_HZ);
      tick     = 1'b1;
    end
    chain_next = chain_reg;
    uip_next   = uip_reg;
    upd_next   = upd_reg;
    if (div_reset) begin
      // Held in reset at mid-count, so release leads to the first update half a second on.
      chain_next = CHAIN_HALF;
    end else if (tick && osc_on) begin
      chain_next = chain_reg + CHAIN_BITS'(1);
    end
    if (tick && upd_ok && (chain_reg == CHAIN_UIP)) begin
      uip_next = 1'b1;
    end
    if (upd_start) begin
      upd_next = UPD_COUNT;
    end else if (tick && (upd_reg != 7'h00)) begin
      upd_next = upd_reg - 7'h01;
      if (upd_reg == 7'h01) begin
        uip_next = 1'b0;
      end
    end
    if (wr_data && (index_reg == IDX_CTRL_B) && port_wdata_in[B_SET_BIT]) begin
      // Raising the halt bit aborts a running update and drops the pending flag.
      uip_next = 1'b0;
      upd_next = 7'h00;
    end
  end

  // Register file: port accesses, update results and flag handling.
  always_comb begin
    tm_next       = tm_reg;
    alm_sec_next  = alm_sec_reg;
    alm_min_next  = alm_min_reg;
    alm_hour_next = alm_hour_reg;
    ctrl_a_next   = ctrl_a_reg;
    ctrl_b_next   = ctrl_b_reg;
    shared_next   = shared_reg;
    index_next    = index_reg;
    vrt_next      = vrt_reg;
    rdata_next    = rdata_reg;
    pf_next       = pf_reg;
    af_next       = af_reg;
    uf_next       = uf_reg;
    if (port_wr_in && !port_data_sel_in && !main_power_reset_in) begin
      index_next = port_wdata_in;
    end
    if (rd_data) begin
      // Time bytes read during an update show whatever is held; software must poll the flag.
      unique case (index_reg)
        IDX_SEC:      rdata_next = tm_reg.sec;
        IDX_SEC_ALM:  rdata_next = alm_sec_reg;
        IDX_MIN:      rdata_next = tm_reg.min;
        IDX_MIN_ALM:  rdata_next = alm_min_reg;
        IDX_HOUR:     rdata_next = tm_reg.hour;
        IDX_HOUR_ALM: rdata_next = alm_hour_reg;
        IDX_WDAY:     rdata_next = tm_reg.wday;
        IDX_MDAY:     rdata_next = tm_reg.mday;
        IDX_MON:      rdata_next = tm_reg.mon;
        IDX_YEAR:     rdata_next = tm_reg.year;
        IDX_CTRL_A:   rdata_next = reg_a;
        IDX_CTRL_B:   rdata_next = ctrl_b_reg;
        IDX_STAT_C:   rdata_next = reg_c;
        IDX_STAT_D:   rdata_next = {vrt_reg, 7'h00};
        IDX_SHARED:   rdata_next = {7'h00, shared_reg};
        default:      rdata_next = 8'h00;
      endcase
      if (index_reg == IDX_STAT_C) begin
        pf_next = 1'b0;
        af_next = 1'b0;
        uf_next = 1'b0;
      end
      if (index_reg == IDX_STAT_D) begin
        vrt_next = 1'b1;
      end
    end
    if (upd_start) begin
      tm_next = tm_adv;
    end
    if (wr_data) begin
      unique case (index_reg)
        IDX_SEC:      tm_next.sec   = port_wdata_in;
        IDX_SEC_ALM:  alm_sec_next  = port_wdata_in;
        IDX_MIN:      tm_next.min   = port_wdata_in;
        IDX_MIN_ALM:  alm_min_next  = port_wdata_in;
        IDX_HOUR:     tm_next.hour  = port_wdata_in;
        IDX_HOUR_ALM: alm_hour_next = port_wdata_in;
        IDX_WDAY:     tm_next.wday  = port_wdata_in;
        IDX_MDAY:     tm_next.mday  = port_wdata_in;
        IDX_MON:      tm_next.mon   = port_wdata_in;
        IDX_YEAR:     tm_next.year  = port_wdata_in;
        IDX_CTRL_A:   ctrl_a_next   = port_wdata_in[6:0];
        IDX_CTRL_B: begin
          ctrl_b_next = port_wdata_in & B_WR_MASK;
          if (port_wdata_in[B_SET_BIT] && !ctrl_b_reg[B_SET_BIT]) begin
            ctrl_b_next[B_UIE_BIT] = 1'b0;
          end
        end
        IDX_SHARED:   shared_next   = port_wdata_in[0] & SHARED_WR_MASK[0];
        default:      shared_next   = shared_reg;
      endcase
    end
    // Events set after the read clear, so a flag raised in the reading cycle survives.
    if (periodic_hit) begin
      pf_next = 1'b1;
    end
    if (tick && (upd_reg == 7'h01)) begin
      uf_next = 1'b1;
    end
    if (upd_start && alarm_hit) begin
      af_next = 1'b1;
    end
    if (main_power_reset_in) begin
      // Main-power reset clears enables and flags but leaves time, divider and flag alone.
      ctrl_b_next[B_PIE_BIT] = 1'b0;
      ctrl_b_next[B_AIE_BIT] = 1'b0;
      ctrl_b_next[B_UIE_BIT] = 1'b0;
      pf_next = 1'b0;
      af_next = 1'b0;
      uf_next = 1'b0;
    end
  end

  // All state registers; only the full reset puts the clock itself in a known state.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      acc_reg      <= 32'h0;
      chain_reg    <= CHAIN_HALF;
      upd_reg      <= 7'h00;
      uip_reg      <= 1'b0;
      tm_reg       <= '{sec: 8'h00, min: 8'h00, hour: 8'h00, wday: DAY_ONE, mday: DAY_ONE,
                        mon: DAY_ONE, year: 8'h00};
      alm_sec_reg  <= 8'h00;
      alm_min_reg  <= 8'h00;
      alm_hour_reg <= 8'h00;
      ctrl_a_reg   <= CTRL_A_RESET;
      ctrl_b_reg   <= CTRL_B_RESET;
      pf_reg       <= 1'b0;
      af_reg       <= 1'b0;
      uf_reg       <= 1'b0;
      vrt_reg      <= 1'b0;
      shared_reg   <= 1'b0;
      index_reg    <= 8'h00;
      rdata_reg    <= 8'h00;
    end else begin
      acc_reg      <= acc_next;
      chain_reg    <= chain_next;
      upd_reg      <= upd_next;
      uip_reg      <= uip_next;
      tm_reg       <= tm_next;
      alm_sec_reg  <= alm_sec_next;
      alm_min_reg  <= alm_min_next;
      alm_hour_reg <= alm_hour_next;
      ctrl_a_reg   <= ctrl_a_next;
      ctrl_b_reg   <= ctrl_b_next;
      pf_reg       <= pf_next;
      af_reg       <= af_next;
      uf_reg       <= uf_next;
      vrt_reg      <= vrt_next;
      shared_reg   <= shared_next;
      index_reg    <= index_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign port_rdata_out          = rdata_reg;
  assign update_pending_flag_out = uip_reg;

endmodule

// ===== rtc_pkg.sv
// Shared constants, types and helper functions of the time-of-day and calendar core.
// Assumes a single 200 MHz system clock, from which the 32.768 KHz time base is derived.
package rtc_pkg;

  // Register indices, as written through the index port.
  localparam logic [7:0] IDX_SEC      = 8'h00;
  localparam logic [7:0] IDX_SEC_ALM  = 8'h01;
  localparam logic [7:0] IDX_MIN      = 8'h02;
  localparam logic [7:0] IDX_MIN_ALM  = 8'h03;
  localparam logic [7:0] IDX_HOUR     = 8'h04;
  localparam logic [7:0] IDX_HOUR_ALM = 8'h05;
  localparam logic [7:0] IDX_WDAY     = 8'h06;
  localparam logic [7:0] IDX_MDAY     = 8'h07;
  localparam logic [7:0] IDX_MON      = 8'h08;
  localparam logic [7:0] IDX_YEAR     = 8'h09;
  localparam logic [7:0] IDX_CTRL_A   = 8'h0a;
  localparam logic [7:0] IDX_CTRL_B   = 8'h0b;
  localparam logic [7:0] IDX_STAT_C   = 8'h0c;
  localparam logic [7:0] IDX_STAT_D   = 8'h0d;
  localparam logic [7:0] IDX_SHARED   = 8'hff;

  // Field positions in the control and status registers.
  localparam int A_UIP_BIT = 7;
  localparam int B_SET_BIT = 7;
  localparam int B_PIE_BIT = 6;
  localparam int B_AIE_BIT = 5;
  localparam int B_UIE_BIT = 4;
  localparam int B_DM_BIT  = 2;
  localparam int B_H24_BIT = 1;
  localparam int C_IRQ_BIT = 7;
  localparam int C_PF_BIT  = 6;
  localparam int C_AF_BIT  = 5;
  localparam int C_UF_BIT  = 4;
  localparam int D_VRT_BIT = 7;

  // Writable masks: read-only and reserved bits are kept out of writes.
  localparam logic [7:0] B_WR_MASK = 8'hf6;
  localparam logic [7:0] SHARED_WR_MASK = 8'h01;

  // Divider control codes.
  localparam logic [2:0] DV_OSC_OFF0 = 3'h0;
  localparam logic [2:0] DV_OSC_OFF1 = 3'h1;
  localparam logic [2:0] DV_NORMAL   = 3'h2;
  localparam logic [1:0] DV_RESET_HI = 2'h3;

  // Reset values after a full (battery) reset.
  localparam logic [6:0] CTRL_A_RESET = 7'h26;
  localparam logic [7:0] CTRL_B_RESET = 8'h02;
  localparam logic [7:0] DAY_ONE      = 8'h01;

  // Time base and update timing.
  localparam longint SYS_HZ        = 200000000;
  localparam longint TB_HZ         = 32768;
  localparam longint UIP_LEAD_US   = 244;
  localparam longint UPDATE_US     = 1948;
  localparam longint LEAD_TICKS    = (UIP_LEAD_US * TB_HZ + 999999) / 1000000;
  // Rounded up, so that the pending flag never drops before the full update interval has passed.
  localparam longint UPD_TICKS     = (UPDATE_US * TB_HZ + 999999) / 1000000;
  localparam int     CHAIN_BITS    = 15;
  localparam logic [CHAIN_BITS-1:0] CHAIN_LAST = 15'h7fff;
  localparam logic [CHAIN_BITS-1:0] CHAIN_HALF = 15'h4000;
  // The flag rises a full lead of ticks before the advance, never fewer.
  localparam logic [CHAIN_BITS-1:0] CHAIN_UIP  = CHAIN_LAST - CHAIN_BITS'(LEAD_TICKS);
  localparam logic [6:0] UPD_COUNT = 7'(UPD_TICKS);

  // Field limits in binary.
  localparam logic [7:0] MAX_SEC   = 8'h3b;
  localparam logic [7:0] MAX_HOUR  = 8'h17;
  localparam logic [7:0] MAX_WDAY  = 8'h07;
  localparam logic [7:0] MAX_MON   = 8'h0c;
  localparam logic [7:0] MAX_YEAR  = 8'h63;
  localparam logic [7:0] HOUR_11   = 8'h0b;
  localparam logic [7:0] HOUR_12   = 8'h0c;
  localparam logic [1:0] WILD_CODE = 2'h3;

  // The seven counting bytes travel together.
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] mon;
    logic [7:0] year;
  } rtc_time_t;

  // Converts a BCD byte to binary.
  function automatic logic [7:0] bcd_to_bin(input logic [7:0] v);
    bcd_to_bin = 8'({4'h0, v[7:4]} * 8'h0a) + {4'h0, v[3:0]};
  endfunction

  // Converts a binary value below 100 to BCD.
  function automatic logic [7:0] bin_to_bcd(input logic [7:0] v);
    bin_to_bcd = {4'(v / 8'h0a), 4'(v % 8'h0a)};
  endfunction

  // Last day of a month, both in binary; years divisible by four are leap years.
  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] year);
    case (mon)
      8'h02:   month_days = (year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
      default: month_days = 8'h1f;
    endcase
  endfunction

endpackage

// ===== rtc_field_step.sv
// One counting field of the calendar: advances a byte by one with wrap and carry.
// Assumes the value is in range for its field; out-of-range values wrap at the top.
`timescale 1ns/1ps

module rtc_field_step (
  input  wire logic [7:0] value_in,   // Current byte, in the selected encoding.
  input  wire logic       binary_in,  // High selects binary, low selects BCD.
  input  wire logic [7:0] low_in,     // Lowest legal value, binary.
  input  wire logic [7:0] high_in,    // Highest legal value, binary.
  input  wire logic       carry_in,   // Advance this field when high.
  output logic      [7:0] value_out,  // Next byte, same encoding.
  output logic            carry_out   // High when the field wrapped.
);
  import rtc_pkg::*;

  logic [7:0] bin_now;  // Current value in binary.
  logic [7:0] bin_nxt;  // Advanced value in binary.

  // The comparison uses >= so that a bad value written by software still recovers.
  always_comb begin
    bin_now   = binary_in ? value_in : bcd_to_bin(value_in);
    bin_nxt   = bin_now;
    carry_out = 1'b0;
    if (carry_in) begin
      if (bin_now >= high_in) begin
        bin_nxt   = low_in;
        carry_out = 1'b1;
      end else begin
        bin_nxt = bin_now + 8'h01;
      end
    end
    value_out = carry_in ? (binary_in ? bin_nxt : bin_to_bcd(bin_nxt)) : value_in;
  end

endmodule

// ===== rtc_time_calendar_update_chk.sv
// Port-level checker for the time-of-day and calendar core.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ps
module rtc_time_calendar_update_chk
  import rtc_pkg::*;
#(
  parameter longint TICK_INC = rtc_pkg::TB_HZ  // Time base added per clock, as in the core.
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       main_power_reset_in,
  input  wire logic       port_data_sel_in,
  input  wire logic       port_wr_in,
  input  wire logic       port_rd_in,
  input  wire logic [7:0] port_wdata_in,
  input  wire logic [7:0] port_rdata_out,
  input  wire logic       update_pending_flag_out
);
  localparam int CPT = int'(SYS_HZ / TICK_INC);  // Clocks per time-base tick.
  logic [7:0]  idx_reg;                           // Mirror of the index port.
  logic [19:0] len_reg;                           // Cycles the flag has been high in a row.
  logic        rd_ok;                             // A data-port read that the core accepts.
  assign rd_ok = port_rd_in && port_data_sel_in && !main_power_reset_in;
  // Helper state; an index write is refused while the main-power reset holds.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) idx_reg <= 8'h00;
    else if (port_wr_in && !port_data_sel_in && !main_power_reset_in) idx_reg <= port_wdata_in;
    len_reg <= update_pending_flag_out ? len_reg + 20'h1 : 20'h0;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence rise_quiet_s;
    $rose(update_pending_flag_out) ##1 (!port_wr_in)[*7];
  endsequence
  AST_RDATA_HOLD: assert property (!rd_ok |=> $stable(port_rdata_out))
    else $error("read data moved without a read");
  AST_FLAG_IN_A: assert property (rd_ok && idx_reg == IDX_CTRL_A |=> port_rdata_out[7] == $past(update_pending_flag_out))
    else $error("pending bit in control A differs from the flag");
  AST_B_RO: assert property (rd_ok && idx_reg == IDX_CTRL_B |=> port_rdata_out[0] == 1'b0 && port_rdata_out[3] == 1'b0)
    else $error("read-only bits of control B not zero");
  AST_SHARED_RO: assert property (rd_ok && idx_reg == IDX_SHARED |=> port_rdata_out[7:1] == 7'h00)
    else $error("read-only bits of shared control not zero");
  AST_FLAG_LEAD: assert property (rise_quiet_s |-> update_pending_flag_out)
    else $error("pending flag dropped during its lead");
  AST_FLAG_LEN: assert property ($fell(update_pending_flag_out) && !$past(port_wr_in) |-> len_reg >= 20'(68 * CPT) && len_reg <= 20'(74 * CPT))
    else $error("pending flag length wrong");
  AST_FLAG_GAP: assert property ($fell(update_pending_flag_out) |-> !update_pending_flag_out[*8])
    else $error("pending flag rose again at once");
  AST_HALT_CLEARS: assert property (port_wr_in && port_data_sel_in && !main_power_reset_in && idx_reg == IDX_CTRL_B && port_wdata_in[7] |=> !update_pending_flag_out[*2])
    else $error("halt write did not clear the pending flag");
endmodule
bind rtc_time_calendar_update rtc_time_calendar_update_chk #(.TICK_INC(TICK_INC)) i_rtc_time_calendar_update_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .main_power_reset_in(main_power_reset_in),
  .port_data_sel_in(port_data_sel_in), .port_wr_in(port_wr_in), .port_rd_in(port_rd_in),
  .port_wdata_in(port_wdata_in), .port_rdata_out(port_rdata_out), .update_pending_flag_out(update_pending_flag_out));

// ===== rtc_time_calendar_update_tb_top.sv
// Self-checking bench for the time-of-day and calendar core.
// Assumes a fast time base: one tick every two clocks, half a second near 32768 clocks.
`timescale 1ns/1ps
module rtc_time_calendar_update_tb_top;
  import rtc_pkg::*;
  logic       clk = 1'b0;       // System clock.
  logic       rst = 1'b1;       // Full reset.
  logic       pwr_rst = 1'b0;   // Main-power reset.
  logic       sel = 1'b0;       // Index or data port.
  logic       wr = 1'b0;        // Write strobe.
  logic       rd = 1'b0;        // Read strobe.
  logic [7:0] wdata = 8'h00;    // Write data.
  logic [7:0] rdata;            // Read data.
  logic       update_pending_flag;              // Update pending flag.
  int         error_cnt = 0;
  int         total_checks = 0;
  always #2.5 clk = ~clk;
  rtc_time_calendar_update #(.TICK_INC(100000000)) i_rtc_time_calendar_update (.sys_clk_in(clk), .rst_in(rst),
    .main_power_reset_in(pwr_rst), .port_data_sel_in(sel), .port_wr_in(wr), .port_rd_in(rd),
    .port_wdata_in(wdata), .port_rdata_out(rdata), .update_pending_flag_out(update_pending_flag));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe on the chosen port; the spare edge lets read data land first.
  task automatic acc(input logic s, input logic w, input logic [7:0] d);
    @(posedge clk);
    sel <= s;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b0, 1'b1, idx);
    acc(1'b1, 1'b1, d);
  endtask
  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, 1'b1, idx);
    acc(1'b1, 1'b0, 8'h00);
    check(rdata, exp);
  endtask
  task automatic s_regs();
    chk_reg(IDX_CTRL_A, 8'h26);
    chk_reg(IDX_CTRL_B, 8'h02);
    wr_reg(IDX_CTRL_A, 8'ha5);
    chk_reg(IDX_CTRL_A, 8'h25);
    wr_reg(IDX_CTRL_B, 8'h07);
    chk_reg(IDX_CTRL_B, 8'h06);
    wr_reg(IDX_SHARED, 8'hff);
    chk_reg(IDX_SHARED, 8'h01);
  endtask
  // Access during main-power reset is refused, and the divider keeps its code.
  task automatic s_pwr();
    wr_reg(IDX_SEC, 8'h12);
    pwr_rst <= 1'b1;
    wr_reg(IDX_SEC, 8'h34);
    chk_reg(IDX_CTRL_B, 8'h01);
    pwr_rst <= 1'b0;
    chk_reg(IDX_SEC, 8'h12);
    chk_reg(IDX_CTRL_A, 8'h25);
  endtask
  // Holds the divider, clears the halt, releases the divider and waits out one update.
  task automatic run_second(input logic [7:0] b_run, input logic [7:0] a_run);
    int n;
    wr_reg(IDX_CTRL_A, 8'h70);
    wr_reg(IDX_CTRL_B, b_run);
    wr_reg(IDX_CTRL_A, a_run);
    n = 0;
    while (!update_pending_flag && n < 40000) begin
      @(posedge clk);
      n++;
    end
    check(8'(n > 32700 && n < 32800), 8'h01);
    while (update_pending_flag && n < 41000) begin
      @(posedge clk);
      n++;
    end
    check(8'(update_pending_flag), 8'h00);
  endtask
  // Last second of a century with wildcard alarms, started from a divider reset.
  task automatic s_update();
    logic [7:0] load [10] = '{8'h59, 8'hc0, 8'h59, 8'hc0, 8'h23, 8'hc0, 8'h07, 8'h31, 8'h12, 8'h99};
    logic [7:0] exp [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h00};
    wr_reg(IDX_CTRL_B, 8'h82);
    for (int i = 0; i < 10; i++) wr_reg(8'(i), load[i]);
    run_second(8'h02, 8'h26);
    for (int i = 0; i < 10; i++) chk_reg(8'(i), exp[i]);
    chk_reg(IDX_STAT_C, 8'h70);
  endtask
  // Leap-year February 28th at 11 PM in binary 12-hour form, exact alarm, periodic rate off.
  task automatic s_12h();
    logic [7:0] load [10] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h0c, 8'h03, 8'h1c, 8'h02, 8'h04};
    logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h04, 8'h1d, 8'h02, 8'h04};
    wr_reg(IDX_CTRL_A, 8'h70);
    chk_reg(IDX_CTRL_A, 8'h70);
    acc(1'b0, 1'b1, IDX_STAT_C);
    acc(1'b1, 1'b0, 8'h00);
    wr_reg(IDX_CTRL_B, 8'h84);
    for (int i = 0; i < 10; i++) wr_reg(8'(i), load[i]);
    run_second(8'h04, 8'h20);
    for (int i = 0; i < 10; i++) chk_reg(8'(i), exp[i]);
    chk_reg(IDX_STAT_C, 8'h30);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_pwr();
    s_update();
    s_12h();
    tally_and_finish();
  end
  // Watchdog: the run needs about 67000 clocks.
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
